// ### rtl/pcs_cfg.svh
// Constants for program counter, return stack and indirect addressing
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PC_WIDTH 13
`define PC_RESET 13'h0000
`define STACK_DEPTH 8
`define STACK_PTR_W 3
`define LATCH_LOW_MSB 4
`define LATCH_TOP_MSB 4
`define LATCH_TOP_LSB 3
`define OPERAND_WIDTH 11
`define INDIRECT_PORT_ADDR 8'h00
`define INDIRECT_READ_VALUE 8'h00
`define DATA_ADDR_WIDTH 9
`endif

// ### rtl/pcs_pkg.sv
// Type for the return stack operation: idle, push or pop
package pcs_pkg;
  typedef enum logic [1:0] {
    stack_idle = 2'b00,
    stack_push = 2'b01,
    stack_pop = 2'b10
  } stack_op_t;
endpackage

// ### rtl/stack_if.sv
// Connection between the program counter core and the return stack
`timescale 1ns/1ps
`include "pcs_cfg.svh"
interface stack_if;
  pcs_pkg::stack_op_t op;
  logic [`PC_WIDTH-1:0] push_data;
  logic [`PC_WIDTH-1:0] top_data;
  modport core (output op, output push_data, input top_data);
  modport stack (input op, input push_data, output top_data);
endinterface

// ### rtl/return_stack.sv
// Eight-entry circular return stack
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module return_stack (
  input wire logic mclk,
  input wire logic rstn,
  stack_if.stack sif
);
  typedef struct packed {
    logic [`STACK_PTR_W-1:0] ptr;
  } rs_state_t;

  rs_state_t state;
  rs_state_t next_state;
  logic [`PC_WIDTH-1:0] entry [`STACK_DEPTH];

  // ------------------------------------------------------------
  // Pointer control
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (sif.op)
      pcs_pkg::stack_push: next_state.ptr = state.ptr + 3'h1;
      pcs_pkg::stack_pop: next_state.ptr = state.ptr - 3'h1;
      default: next_state = state;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sif.op == pcs_pkg::stack_push) begin
      entry[state.ptr] <= sif.push_data;
    end
  end

  // Top entry sits just below the pointer; wraps when empty
  assign sif.top_data = entry[state.ptr - 3'h1];
endmodule

// ### rtl/indirect_addr.sv
// Indirect data address formation
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module indirect_addr (
  input wire logic bank_pointer_bit,
  input wire logic [7:0] pointer_reg,
  input wire logic [7:0] file_addr,
  input wire logic [7:0] mem_rdata,
  output logic [`DATA_ADDR_WIDTH-1:0] eff_addr,
  output logic is_indirect,
  output logic self_ref,
  output logic [7:0] rdata
);
  // ------------------------------------------------------------
  // Address select
  // ------------------------------------------------------------
  always_comb begin
    is_indirect = (file_addr == `INDIRECT_PORT_ADDR);
    self_ref = is_indirect && (pointer_reg == `INDIRECT_PORT_ADDR);
    if (is_indirect) begin
      eff_addr = {bank_pointer_bit, pointer_reg};
    end else begin
      eff_addr = {1'b0, file_addr};
    end
    rdata = self_ref ? `INDIRECT_READ_VALUE : mem_rdata;
  end
endmodule

// ### rtl/program_counter_stack_indirect.sv
// Program counter, return stack and indirect data access of the core
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module program_counter_stack_indirect (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic instr_step,
  input wire logic jump_instr,
  input wire logic subroutine_call_instr,
  input wire logic return_instr,
  input wire logic return_literal_instr,
  input wire logic return_from_interrupt_instr,
  input wire logic interrupt_vector,
  input wire logic [`PC_WIDTH-1:0] interrupt_vector_addr,
  input wire logic [`OPERAND_WIDTH-1:0] operand,
  input wire logic file_write,
  input wire logic [7:0] file_addr,
  input wire logic [7:0] file_wdata,
  input wire logic pc_low_addr_match,
  input wire logic pc_high_latch_write,
  input wire logic [7:0] pc_high_latch_wdata,
  input wire logic pointer_write,
  input wire logic [7:0] pointer_wdata,
  input wire logic bank_pointer_bit,
  input wire logic [7:0] mem_rdata,
  output logic [`PC_WIDTH-1:0] pc,
  output logic [7:0] pc_low_byte,
  output logic [7:0] pc_high_latch,
  output logic [7:0] pointer_reg,
  output logic [`DATA_ADDR_WIDTH-1:0] data_addr,
  output logic data_write,
  output logic [7:0] data_wdata,
  output logic [7:0] indirect_rdata
);
  // ------------------------------------------------------------
  // Types and state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [`PC_WIDTH-1:0] pc;
    logic [7:0] latch;
    logic [7:0] pointer;
  } core_state_t;

  typedef enum logic [2:0] {
    src_hold = 3'b000,
    src_vector = 3'b001,
    src_branch = 3'b010,
    src_return = 3'b011,
    src_low_write = 3'b100,
    src_step = 3'b101
  } pc_src_t;

  core_state_t state;
  core_state_t next_state;
  logic is_indirect;
  logic self_ref;
  logic any_branch;
  logic any_return;
  logic pc_low_write;
  pc_src_t pc_src;
  logic [`PC_WIDTH-1:0] pc_inc;
  logic [`PC_WIDTH-1:0] branch_pc;
  logic [`PC_WIDTH-1:0] low_write_pc;
  logic [`PC_WIDTH-1:0] push_value;

  stack_if sif ();

  // ------------------------------------------------------------
  // Target helpers
  // ------------------------------------------------------------
  function automatic logic [`PC_WIDTH-1:0] jump_target(
    input logic [7:0] latch,
    input logic [`OPERAND_WIDTH-1:0] opnd
  );
    jump_target = {latch[`LATCH_TOP_MSB:`LATCH_TOP_LSB], opnd};
  endfunction

  function automatic logic [`PC_WIDTH-1:0] low_write_target(
    input logic [7:0] latch,
    input logic [7:0] low
  );
    low_write_target = {latch[`LATCH_LOW_MSB:0], low};
  endfunction

  function automatic logic [`PC_WIDTH-1:0] step_target(
    input logic [`PC_WIDTH-1:0] cur
  );
    step_target = cur + 13'h0001;
  endfunction

  function automatic logic [`PC_WIDTH-1:0] return_address(
    input logic vec,
    input logic [`PC_WIDTH-1:0] cur,
    input logic [`PC_WIDTH-1:0] step
  );
    return_address = vec ? cur : step;
  endfunction

  // ------------------------------------------------------------
  // Register write helper
  // ------------------------------------------------------------
  function automatic logic [7:0] write_or_hold(
    input logic wr,
    input logic [7:0] wdata,
    input logic [7:0] cur
  );
    write_or_hold = wr ? wdata : cur;
  endfunction

  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  function automatic logic is_return_code(
    input logic ret,
    input logic ret_lit,
    input logic ret_int
  );
    is_return_code = ret || ret_lit || ret_int;
  endfunction

  // Interrupt first, then branch, return, low-byte write, step
  function automatic pc_src_t select_source(
    input logic step,
    input logic vec,
    input logic branch,
    input logic ret,
    input logic low_write
  );
    if (!step) begin
      select_source = src_hold;
    end else if (vec) begin
      select_source = src_vector;
    end else if (branch) begin
      select_source = src_branch;
    end else if (ret) begin
      select_source = src_return;
    end else if (low_write) begin
      select_source = src_low_write;
    end else begin
      select_source = src_step;
    end
  endfunction

  // ------------------------------------------------------------
  // Stack action
  // ------------------------------------------------------------
  function automatic pcs_pkg::stack_op_t stack_action(
    input pc_src_t src,
    input logic call
  );
    stack_action = pcs_pkg::stack_idle;
    unique case (src)
      src_hold: stack_action = pcs_pkg::stack_idle;
      src_vector: stack_action = pcs_pkg::stack_push;
      src_branch: stack_action = call ? pcs_pkg::stack_push : pcs_pkg::stack_idle;
      src_return: stack_action = pcs_pkg::stack_pop;
      src_low_write: stack_action = pcs_pkg::stack_idle;
      src_step: stack_action = pcs_pkg::stack_idle;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Counter source mux
  // ------------------------------------------------------------
  function automatic logic [`PC_WIDTH-1:0] next_pc_value(
    input pc_src_t src,
    input logic [`PC_WIDTH-1:0] cur,
    input logic [`PC_WIDTH-1:0] vec_pc,
    input logic [`PC_WIDTH-1:0] branch_target,
    input logic [`PC_WIDTH-1:0] popped,
    input logic [`PC_WIDTH-1:0] low_target,
    input logic [`PC_WIDTH-1:0] step_pc
  );
    next_pc_value = cur;
    unique case (src)
      src_hold: next_pc_value = cur;
      src_vector: next_pc_value = vec_pc;
      src_branch: next_pc_value = branch_target;
      src_return: next_pc_value = popped;
      src_low_write: next_pc_value = low_target;
      src_step: next_pc_value = step_pc;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Return stack
  // ------------------------------------------------------------
  return_stack u_stack (
    .mclk(mclk),
    .rstn(rstn),
    .sif(sif.stack)
  );

  // ------------------------------------------------------------
  // Indirect addressing
  // ------------------------------------------------------------
  indirect_addr u_ind (
    .bank_pointer_bit(bank_pointer_bit),
    .pointer_reg(state.pointer),
    .file_addr(file_addr),
    .mem_rdata(mem_rdata),
    .eff_addr(data_addr),
    .is_indirect(is_indirect),
    .self_ref(self_ref),
    .rdata(indirect_rdata)
  );

  // ------------------------------------------------------------
  // Flow decode
  // ------------------------------------------------------------
  assign any_branch = subroutine_call_instr || jump_instr;
  assign any_return = is_return_code(
    return_instr,
    return_literal_instr,
    return_from_interrupt_instr
  );
  assign pc_low_write = file_write && pc_low_addr_match && !is_indirect;
  assign pc_src = select_source(
    instr_step,
    interrupt_vector,
    any_branch,
    any_return,
    pc_low_write
  );
  assign pc_inc = step_target(state.pc);
  assign branch_pc = jump_target(state.latch, operand);
  assign low_write_pc = low_write_target(state.latch, file_wdata);
  assign push_value = return_address(interrupt_vector, state.pc, pc_inc);

  // ------------------------------------------------------------
  // Stack control
  // ------------------------------------------------------------
  // Jumps never pop, so a return beside a branch is dropped
  assign sif.op = stack_action(pc_src, subroutine_call_instr);
  assign sif.push_data = push_value;

  // ------------------------------------------------------------
  // Data access
  // ------------------------------------------------------------
  assign data_write = file_write && !self_ref;
  assign data_wdata = file_wdata;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.latch = write_or_hold(
      pc_high_latch_write,
      pc_high_latch_wdata,
      state.latch
    );
    next_state.pointer = write_or_hold(
      pointer_write,
      pointer_wdata,
      state.pointer
    );
    next_state.pc = next_pc_value(
      pc_src,
      state.pc,
      interrupt_vector_addr,
      branch_pc,
      sif.top_data,
      low_write_pc,
      pc_inc
    );
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign pc = state.pc;
  assign pc_low_byte = state.pc[7:0];
  assign pc_high_latch = state.latch;
  assign pointer_reg = state.pointer;
endmodule

// ### verification/exec_stage_model.sv
// Decoder model turning an instruction code into flow strobes
`timescale 1ns/1ps
module exec_stage_model (
  input wire logic [2:0] code,
  output logic jump_instr,
  output logic subroutine_call_instr,
  output logic return_instr,
  output logic return_literal_instr,
  output logic return_from_interrupt_instr
);
  assign {return_from_interrupt_instr, return_literal_instr, return_instr, subroutine_call_instr,
    jump_instr} = 5'(6'(6'h01 << code) >> 1);
endmodule

// ### verification/pcs_sva.sv
// Port checker for the program counter block
`timescale 1ns/1ps
module pcs_sva (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic instr_step,
  input wire logic jump_instr,
  input wire logic subroutine_call_instr,
  input wire logic return_instr,
  input wire logic return_literal_instr,
  input wire logic return_from_interrupt_instr,
  input wire logic interrupt_vector,
  input wire logic [12:0] interrupt_vector_addr,
  input wire logic [10:0] operand,
  input wire logic file_write,
  input wire logic [7:0] file_addr,
  input wire logic [7:0] file_wdata,
  input wire logic pc_low_addr_match,
  input wire logic pc_high_latch_write,
  input wire logic bank_pointer_bit,
  input wire logic [12:0] pc,
  input wire logic [7:0] pc_high_latch,
  input wire logic [7:0] pointer_reg,
  input wire logic [8:0] data_addr,
  input wire logic data_write,
  input wire logic [7:0] indirect_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic go, jc, ind, inc, plain, lw;
  logic [12:0] tgt;
  assign go = instr_step & !interrupt_vector;
  assign jc = go & (jump_instr | subroutine_call_instr);
  assign ind = file_addr == 8'h00;
  assign plain = go & !jc & !return_instr & !return_literal_instr & !return_from_interrupt_instr;
  assign lw = plain & file_write & pc_low_addr_match & !ind;
  assign inc = plain & !lw;
  assign tgt = {pc_high_latch[4:3], operand};
  a_reset_clear: assert property (disable iff (1'b0) !rstn [*2] |-> pc == 13'h0)
    else $error("pc not cleared");
  a_jump_target: assert property (jc |=> pc == $past(tgt))
    else $error("bad jump target");
  a_step_incr: assert property (inc |=> pc == $past(pc) + 13'h1)
    else $error("pc not advanced");
  a_int_vector: assert property (instr_step && interrupt_vector
    |=> pc == $past(interrupt_vector_addr))
    else $error("bad vector");
  a_low_load: assert property (lw
    |=> pc == {$past(pc_high_latch[4:0]), $past(file_wdata)})
    else $error("bad low byte load");
  a_pc_hold: assert property (!instr_step |=> $stable(pc))
    else $error("pc moved idle");
  a_latch_kept: assert property (!pc_high_latch_write |=> $stable(pc_high_latch))
    else $error("latch changed");
  a_ind_addr: assert property (ind |-> data_addr == {bank_pointer_bit, pointer_reg})
    else $error("bad data address");
  a_self_ref: assert property (ind && pointer_reg == 8'h00
    |-> indirect_rdata == 8'h00 && !data_write)
    else $error("self access leaked");
endmodule
bind program_counter_stack_indirect pcs_sva u_pcs_sva (.*);

// ### verification/program_counter_stack_indirect_tb.sv
// Random bench comparing the program counter block with a model
`timescale 1ns/1ps
module program_counter_stack_indirect_tb;
  logic mclk = 0, rstn = 0, instr_step = 0, interrupt_vector = 0, file_write = 0, w, s;
  logic pc_low_addr_match = 0, pc_high_latch_write = 0, pointer_write = 0, bank_pointer_bit = 0;
  logic jump_instr, subroutine_call_instr, return_instr, return_literal_instr;
  logic return_from_interrupt_instr, data_write;
  logic [2:0] code = 0;
  logic [10:0] operand = 0;
  logic [12:0] interrupt_vector_addr = 0, pc, mpc, stk [8];
  logic [7:0] file_addr = 0, file_wdata = 0, pc_high_latch_wdata = 0, pointer_wdata = 0;
  logic [7:0] mem_rdata = 0, pc_low_byte, pc_high_latch, pointer_reg, data_wdata, indirect_rdata;
  logic [7:0] mlat, mptr;
  logic [8:0] data_addr;
  logic [31:0] r;
  int seed = 32'h76a6, sp, miscompares, total_checks, cyc;
  exec_stage_model u_exec_stage_model (.*);
  program_counter_stack_indirect u_program_counter_stack_indirect (.*);
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (total_checks > 0 && miscompares == 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic push(input logic [12:0] v);
    stk[sp] = v;
    sp = (sp + 1) % 8;
  endtask
  initial begin
    for (int k = 0; k < 2; k++) begin
      rstn = 0;
      {instr_step, interrupt_vector, file_write, pc_high_latch_write, pointer_write} = 5'h00;
      repeat (20) @(posedge mclk);
      #1;
      rstn = 1;
      {mpc, mlat, mptr, sp} = 0;
      for (int i = 0; i < 1000; i++) begin
        chk(pc, mpc);
        chk(pc_low_byte, mpc[7:0]);
        chk(pc_high_latch, mlat);
        chk(pointer_reg, mptr);
        w = k == 0 && i < 8;
        {operand, file_write, pc_low_addr_match, pc_high_latch_write, pointer_write,
          bank_pointer_bit, file_wdata, pc_high_latch_wdata} = $random(seed);
        {interrupt_vector_addr, mem_rdata, code, file_addr} = $random(seed);
        r = $random(seed);
        instr_step = w | r[0];
        interrupt_vector = !w && r[4:1] == 4'h0;
        pointer_wdata = r[5] ? 8'h00 : r[13:6];
        if (r[14]) file_addr = 8'h00;
        if (w) code = 3'h2;
        #1;
        s = file_addr == 8'h00 && mptr == 8'h00;
        chk(data_addr, file_addr == 8'h00 ? {bank_pointer_bit, mptr}
          : {1'b0, file_addr});
        chk(data_wdata, file_wdata);
        chk(indirect_rdata, s ? 8'h00 : mem_rdata);
        chk(data_write, file_write && !s);
        if (instr_step) begin
          if (interrupt_vector) begin
            push(mpc);
            mpc = interrupt_vector_addr;
          end else if (jump_instr | subroutine_call_instr) begin
            if (subroutine_call_instr) push(mpc + 13'h1);
            mpc = {mlat[4:3], operand};
          end else if (return_instr | return_literal_instr | return_from_interrupt_instr) begin
            sp = (sp + 7) % 8;
            mpc = stk[sp];
          end else if (file_write & pc_low_addr_match & file_addr != 0) begin
            mpc = {mlat[4:0], file_wdata};
          end else begin
            mpc = mpc + 13'h1;
          end
        end
        if (pc_high_latch_write) mlat = pc_high_latch_wdata;
        if (pointer_write) mptr = pointer_wdata;
        @(posedge mclk);
        #1;
      end
    end
    complete_run();
  end
endmodule
